// ---- common/supply_fault_pkg.sv ----
package supply_fault_pkg;

  // ****************************************
  // register map (word offsets are byte addresses)
  // ****************************************
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] DIAG_OFFSET   = 8'h04;
  localparam logic [7:0] GPIO_OFFSET   = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFFSET = 8'h0c;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'h10;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_SLEEP_BIT     = 0;
  localparam int DIAG_SUPPLY_ERR_BIT = 0;
  localparam int GPIO_IO_UV_BIT     = 0;
  localparam int GPIO_IO_OK_BIT     = 1;
  localparam int IRQ_CORE_UV_BIT    = 0;
  localparam int IRQ_AUX_OC_BIT     = 1;
  localparam int IRQ_IO_UV_BIT      = 2;
  localparam int IRQ_IO_OK_BIT      = 3;
  localparam int IRQ_W              = 4;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;
  localparam logic             DIAG_RESET     = 1'b0;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ                 = 100;
  localparam int SUPPLY_FAULT_DEGLITCH_NS = 15000;
  localparam int DEGLITCH_CYCLES =
    SUPPLY_FAULT_DEGLITCH_NS * CLK_MHZ / 1000;
  localparam int DEG_W = 11;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic core_uv;
    logic aux_oc;
    logic io_uv;
  } fault_in_t;

endpackage

// ---- hw/supply_fault_supervisor.sv ----
// Contract
// RULE_01 - writing one to the sleep request bit sends the device to sleep.
// RULE_02 - qualified core undervoltage forces sleep and latches supply error.
// RULE_03 - qualified auxiliary overcurrent switches the regulator off.
// RULE_04 - qualified overcurrent also forces sleep and sets supply error.
// RULE_05 - qualified io undervoltage sets the io flag without sleep.
// RULE_06 - the io flag clears on a write only after qualified supply good.
// RULE_07 - gpio function and gpio wake need the io undervoltage flag at zero.
// RULE_08 - every fault is qualified for about 15 us, 8 to 24 us, first.
// RULE_09 - each deglitch counter restarts whenever its comparator drops.
`timescale 1ns/1ps
module supply_fault_supervisor
  import supply_fault_pkg::*;
(
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  input  wire supply_fault_pkg::wb_req_t  wb_req,
  output      supply_fault_pkg::wb_rsp_t  wb_rsp,
  input  wire supply_fault_pkg::fault_in_t fault_in,
  output      logic                       sleep_enter,
  output      logic                       aux_reg_enable,
  output      logic                       gpio_enable,
  output      logic                       gpio_wake_enable,
  output      logic                       irq
);
  import supply_fault_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [2:0]       sync1;
    logic [2:0]       sync2;
    logic [DEG_W-1:0] cnt_core;
    logic [DEG_W-1:0] cnt_aux;
    logic [DEG_W-1:0] cnt_io_low;
    logic [DEG_W-1:0] cnt_io_ok;
    logic             sleep;
    logic             aux_off;
    logic             supply_err;
    logic             io_uv;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic             ack;
    logic [31:0]      rdat;
  } state_t;

  localparam logic [DEG_W-1:0] DEG_LIMIT = DEG_W'(DEGLITCH_CYCLES);

  state_t state_reg;
  state_t state_next;

  logic [2:0]       qual;
  logic             io_good;
  logic             bus_hit;
  logic             wr;
  logic [IRQ_W-1:0] ev;

  always_comb begin
    state_next = state_reg;
    // comparators are asynchronous, two flops before use
    state_next.sync1 = {fault_in.io_uv, fault_in.aux_oc, fault_in.core_uv};
    state_next.sync2 = state_reg.sync1;
    qual = 3'h0;
    io_good = 1'b0;

    // ****************************************
    // deglitch counters
    // ****************************************
    // restart on any drop, saturate once qualified
    if (!state_reg.sync2[0]) begin
      state_next.cnt_core = '0; // RULE_09
    end else if (state_reg.cnt_core != DEG_LIMIT) begin
      state_next.cnt_core = state_reg.cnt_core + 1'b1; // RULE_08
    end
    if (!state_reg.sync2[1]) begin
      state_next.cnt_aux = '0; // RULE_09
    end else if (state_reg.cnt_aux != DEG_LIMIT) begin
      state_next.cnt_aux = state_reg.cnt_aux + 1'b1; // RULE_08
    end
    if (!state_reg.sync2[2]) begin
      state_next.cnt_io_low = '0; // RULE_09
    end else if (state_reg.cnt_io_low != DEG_LIMIT) begin
      state_next.cnt_io_low = state_reg.cnt_io_low + 1'b1; // RULE_08
    end
    if (state_reg.sync2[2]) begin
      state_next.cnt_io_ok = '0; // RULE_09
    end else if (state_reg.cnt_io_ok != DEG_LIMIT) begin
      state_next.cnt_io_ok = state_reg.cnt_io_ok + 1'b1;
    end
    qual[0] = state_reg.cnt_core == DEG_LIMIT; // RULE_08
    qual[1] = state_reg.cnt_aux == DEG_LIMIT; // RULE_08
    qual[2] = state_reg.cnt_io_low == DEG_LIMIT; // RULE_08
    io_good = state_reg.cnt_io_ok == DEG_LIMIT; // RULE_06

    // ****************************************
    // bus
    // ****************************************
    bus_hit = wb_req.cyc && wb_req.stb && !state_reg.ack;
    wr = bus_hit && wb_req.we && wb_req.sel[0];
    state_next.ack = bus_hit;
    state_next.rdat = 32'h0000_0000;
    if (bus_hit && !wb_req.we) begin
      case (wb_req.adr)
        CTRL_OFFSET:
          state_next.rdat[CTRL_SLEEP_BIT] = state_reg.sleep;
        DIAG_OFFSET:
          state_next.rdat[DIAG_SUPPLY_ERR_BIT] = state_reg.supply_err;
        GPIO_OFFSET: begin
          state_next.rdat[GPIO_IO_UV_BIT] = state_reg.io_uv;
          state_next.rdat[GPIO_IO_OK_BIT] = io_good;
        end
        IRQ_STAT_OFFSET:
          state_next.rdat[IRQ_W-1:0] = state_reg.irq_stat;
        IRQ_MASK_OFFSET:
          state_next.rdat[IRQ_W-1:0] = state_reg.irq_mask;
        default:
          state_next.rdat = 32'h0000_0000;
      endcase
    end

    // ****************************************
    // supervision actions
    // ****************************************
    if (wr && wb_req.adr == CTRL_OFFSET
        && wb_req.dat[CTRL_SLEEP_BIT]) begin
      state_next.sleep = 1'b1; // RULE_01
    end
    if (qual[0]) begin
      state_next.sleep = 1'b1; // RULE_02
      state_next.supply_err = 1'b1; // RULE_02
    end
    if (qual[1]) begin
      state_next.aux_off = 1'b1; // RULE_03
      state_next.sleep = 1'b1; // RULE_04
      state_next.supply_err = 1'b1; // RULE_04
    end
    // diag flag survives sleep; software clears by writing one
    if (wr && wb_req.adr == DIAG_OFFSET
        && wb_req.dat[DIAG_SUPPLY_ERR_BIT] && !qual[0] && !qual[1]) begin
      state_next.supply_err = 1'b0;
    end
    // clear accepted only with supply good; a new fault wins
    if (wr && wb_req.adr == GPIO_OFFSET && wb_req.dat[GPIO_IO_UV_BIT]
        && io_good) begin
      state_next.io_uv = 1'b0; // RULE_06
    end
    if (qual[2]) begin
      state_next.io_uv = 1'b1; // RULE_05
    end

    // ****************************************
    // interrupts
    // ****************************************
    ev = {io_good && !state_reg.irq_stat[IRQ_IO_OK_BIT] && state_reg.io_uv,
          qual[2] && !state_reg.io_uv,
          qual[1] && !state_reg.aux_off,
          qual[0] && !state_reg.sleep};
    if (wr && wb_req.adr == IRQ_STAT_OFFSET) begin
      state_next.irq_stat = state_reg.irq_stat & ~wb_req.dat[IRQ_W-1:0];
    end
    state_next.irq_stat = state_next.irq_stat | ev;
    if (wr && wb_req.adr == IRQ_MASK_OFFSET) begin
      state_next.irq_mask = wb_req.dat[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
      state_reg.supply_err <= DIAG_RESET;
      state_reg.irq_mask <= IRQ_MASK_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign wb_rsp.ack = state_reg.ack;
  assign wb_rsp.dat = state_reg.rdat;
  assign sleep_enter = state_reg.sleep;
  assign aux_reg_enable = !state_reg.aux_off;
  assign gpio_enable = !state_reg.io_uv; // RULE_07
  assign gpio_wake_enable = !state_reg.io_uv; // RULE_07
  assign irq = |(state_reg.irq_stat & state_reg.irq_mask);

endmodule

// ---- testbench/supply_fault_chk.sv ----
`timescale 1ns/1ps
module supply_fault_chk
  import supply_fault_pkg::*;
(
  input wire logic                        clk_sys,
  input wire logic                        rst_n,
  input wire supply_fault_pkg::wb_req_t   wb_req,
  input wire supply_fault_pkg::wb_rsp_t   wb_rsp,
  input wire supply_fault_pkg::fault_in_t fault_in,
  input wire logic                        sleep_enter,
  input wire logic                        aux_reg_enable,
  input wire logic                        gpio_enable,
  input wire logic                        gpio_wake_enable,
  input wire logic                        irq
);
  // ****
  // run length of aux overcurrent and io undervoltage faults, saturating
  // ****
  logic [11:0] oc_reg;
  logic [11:0] uv_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      oc_reg <= 12'h000;
      uv_reg <= 12'h000;
    end else begin
      oc_reg <= fault_in.aux_oc ? oc_reg + 12'(oc_reg != 12'hfff) : 12'h000;
      uv_reg <= fault_in.io_uv ? uv_reg + 12'(uv_reg != 12'hfff) : 12'h000;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_ack_take;
    wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack;
  endproperty
  a_ack_take: assert property (p_ack_take) else $error("ack late");
  property p_ack_one; wb_rsp.ack |=> !wb_rsp.ack; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_dat_idle; !wb_rsp.ack |-> wb_rsp.dat == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("dat not idle");
  property p_sleep_hold; sleep_enter |=> sleep_enter; endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("sleep left");
  property p_aux_hold; !aux_reg_enable |=> !aux_reg_enable; endproperty
  a_aux_hold: assert property (p_aux_hold) else $error("aux back on");
  property p_aux_sleep; $fell(aux_reg_enable) |-> ##[0:4] sleep_enter; endproperty
  a_aux_sleep: assert property (p_aux_sleep) else $error("no sleep");
  property p_io_nosleep; $fell(gpio_enable) |-> $stable(sleep_enter); endproperty
  a_io_nosleep: assert property (p_io_nosleep) else $error("io slept");
  property p_gpio_eq; gpio_enable == gpio_wake_enable; endproperty
  a_gpio_eq: assert property (p_gpio_eq) else $error("gpio differ");
  property p_oc_deg;
    $fell(aux_reg_enable) |-> oc_reg >= 12'd800 && oc_reg <= 12'd2400;
  endproperty
  a_oc_deg: assert property (p_oc_deg) else $error("oc too soon");
  property p_uv_deg;
    $fell(gpio_enable) |-> uv_reg >= 12'd800 && uv_reg <= 12'd2400;
  endproperty
  a_uv_deg: assert property (p_uv_deg) else $error("uv too soon");
  c_sleep: cover property ($rose(sleep_enter));
  c_aux: cover property ($fell(aux_reg_enable));
  c_gpio: cover property ($fell(gpio_enable));
endmodule
bind supply_fault_supervisor supply_fault_chk u_chk (.clk_sys(clk_sys),
  .rst_n(rst_n), .wb_req(wb_req), .wb_rsp(wb_rsp), .fault_in(fault_in),
  .sleep_enter(sleep_enter), .aux_reg_enable(aux_reg_enable),
  .gpio_enable(gpio_enable), .gpio_wake_enable(gpio_wake_enable), .irq(irq));

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
module tb;
  import supply_fault_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  wb_req_t     req = '0;
  wb_rsp_t     rsp;
  fault_in_t   fi = '0;
  logic        sl, aux, gp, gw, irq;
  logic [31:0] q, seed = 32'h7161;
  int          errors = 0, num_checks = 0, n;
  always #5 clk_sys = ~clk_sys;
  supply_fault_supervisor dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .wb_req(req), .wb_rsp(rsp), .fault_in(fi), .sleep_enter(sl),
    .aux_reg_enable(aux), .gpio_enable(gp), .gpio_wake_enable(gw), .irq(irq));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // ****
  // the model: each fault index maps to one action
  // ****
  function automatic logic act(input int k);
    return k == 0 ? sl : k == 1 ? !aux : !gp;
  endfunction
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t = 0;
    @(posedge clk_sys);
    req <= '{1'b1, 1'b1, w, a, 4'hf, d};
    do @(posedge clk_sys); while (rsp.ack !== 1'b1 && ++t < 50);
    if (rsp.ack !== 1'b1) begin
      errors++;
      $display("mismatch %0t no ack", $time);
    end
    q = rsp.dat;
    req <= '0;
    @(posedge clk_sys);
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clk_sys);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #500us;
    errors++;
    final_report;
  end
  initial begin
    for (int k = 0; k < 3; k++) begin
      rst_n <= 1'b0;
      fi <= '0;
      wt(20);
      rst_n <= 1'b1;
      wt(1);
      chk(32'h3, {sl, aux, gp});
      fi[2-k] <= 1'b1;
      wt(700);
      fi <= '0;
      wt(20);
      chk(0, act(k));
      fi[2-k] <= 1'b1;
      n = 0;
      while (act(k) !== 1'b1 && n < 3000) begin
        wt(1);
        n++;
      end
      chk(1, n >= 800 && n <= 2400);
      wt(5);
      chk(k < 2, sl);
      chk(k != 1, aux);
      wb(0, DIAG_OFFSET, 0);
      chk(k < 2, q);
      wb(0, IRQ_STAT_OFFSET, 0);
      chk(1 << k, q);
      seed = lfsr(seed);
      wb(1, IRQ_MASK_OFFSET, seed);
      wb(0, IRQ_MASK_OFFSET, 0);
      chk(seed & 32'hf, q);
      chk(seed[k], irq);
      if (k == 2) begin
        wb(1, GPIO_OFFSET, 1);
        chk(0, gp);
        fi <= '0;
        wt(1600);
        wb(1, GPIO_OFFSET, 1);
        wt(2);
        chk(1, gp & gw);
      end
      fi <= '0;
      wb(1, IRQ_STAT_OFFSET, 32'hf);
      wb(0, IRQ_STAT_OFFSET, 0);
      chk(0, q);
      chk(0, irq);
      $display("test %0d done", k);
    end
    chk(0, sl);
    wb(1, CTRL_OFFSET, 1);
    wt(3);
    chk(1, sl);
    wb(0, 8'h20, 0);
    chk(0, q);
    final_report;
  end
endmodule
